// [prom_device_model.sv]
// Behavioural PROM device held in programming mode, facing the programmer.
// Assumes one programmer on the pins; unwritten bytes read as ff.
`timescale 1ns/1ps
module prom_device_model (
	input wire logic [1:0] port3_low_i,
	input wire logic port3_bit2_i,
	input wire logic port3_bit3_i,
	input wire logic [1:0] port4_low_i,
	input wire logic vref_i,
	input wire logic [6:0] port1_upper_pins_i,
	input wire logic [3:0] port2_low_pins_i,
	input wire logic reset_n_i,
	input wire logic [7:0] host_data_i,
	input wire logic host_oe_i,
	input wire logic corrupt_i,
	output logic [7:0] bus_o
);
	logic [7:0] mem [0:32767];
	logic [7:0] last;
	logic [14:0] addr;
	logic dev_oe;
	initial for (int i = 0; i < 32768; i++) mem[i] = 8'hff;
	assign addr = {port4_low_i, port3_low_i, port1_upper_pins_i, port2_low_pins_i};
	assign dev_oe = !reset_n_i && !port3_bit2_i && (!vref_i || port3_bit3_i);
	always @(negedge vref_i) begin
		if (!reset_n_i && port3_bit2_i && port3_bit3_i) begin
			mem[addr] = bus_o;
		end
	end
	always @* begin
		if (dev_oe && host_oe_i) begin
			bus_o = 8'hxx;
		end else if (dev_oe) begin
			bus_o = mem[addr] ^ {7'h00, corrupt_i};
		end else if (host_oe_i) begin
			bus_o = host_data_i;
		end else begin
			bus_o = ~last;
		end
	end
	// Floating bus must not look like held data
	always @* begin
		if (dev_oe ^ host_oe_i) begin
			last = bus_o;
		end
	end
endmodule : prom_device_model

// [prom_pin_map.sv]
// Maps the logical programming pins onto the device port pins.
// Assumes the device is held in programming mode by reset_n low.
`timescale 1ns/1ps
module prom_pin_map
	import prom_prog_pkg::*;
(
	input wire pins_s pins_i,
	output logic [1:0] port3_low_o,
	output logic port3_bit2_o,
	output logic port3_bit3_o,
	output logic [1:0] port4_low_o,
	output logic vref_o,
	output logic [6:0] port1_upper_pins_o,
	output logic [3:0] port2_low_pins_o,
	output logic reset_n_o
);
	always_comb begin
		port2_low_pins_o = pins_i.prom_word_index[3:0];
		port1_upper_pins_o = pins_i.prom_word_index[10:4];
		port3_low_o = pins_i.prom_word_index[12:11];
		port4_low_o = pins_i.prom_word_index[14:13];
		port3_bit2_o = pins_i.out_en_n;
		port3_bit3_o = pins_i.vpp_on;
		vref_o = pins_i.chip_en_n;
		reset_n_o = pins_i.reset_n;
	end
endmodule : prom_pin_map

// [prom_prog_params.svh]
// Constants for the PROM programmer controller.
// Assumes a 125 MHz clock; pin timing counts are in clock cycles.
`ifndef PROM_PROG_PARAMS_SVH
`define PROM_PROG_PARAMS_SVH

`define ADDR_W 15
`define DATA_W 8
`define SMALL_LO 15'h6000
`define LARGE_LO 15'h4000
`define AREA_HI 15'h7fff
`define CLK_PERIOD_NS 8
// Setup before strobe and strobe width, in ns
`define SETUP_NS 100
`define PULSE_NS 1000
`define SETUP_CYC ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PULSE_CYC ((`PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W 8

`endif

// [prom_prog_pkg.sv]
// Types shared by the PROM programmer controller.
// Assumes prom_prog_params.svh is included beforehand.
`include "prom_prog_params.svh"
package prom_prog_pkg;
	typedef enum logic [1:0] {
		OP_READ,
		OP_WRITE,
		OP_VERIFY
	} op_e;

	// Pins toward the device in programming mode
	typedef struct packed {
		logic reset_n;
		logic chip_en_n;
		logic out_en_n;
		logic vpp_on;
		logic [`ADDR_W-1:0] prom_word_index;
	} pins_s;

	typedef struct packed {
		op_e op;
		logic [`ADDR_W-1:0] addr;
		logic [`DATA_W-1:0] data;
	} req_s;
endpackage : prom_prog_pkg

// [prom_programmer.sv]
// PROM programmer controller: reads, writes and verifies PROM bytes.
// Assumes the adapter turns port3_bit3_o into the programming voltage and that
// port1_bit0, port4 bits two/three and port5 are left unconnected.
// Function
// - Hold reset low for programming mode
// - OE high, VPP on before writing
// - Present address and data together
// - CE low strobe programs the byte
// - Verify: VPP, CE high, OE low
// - Small variant: 6000 to 7fff only
// - Large variant: 4000 to 7fff only
// - Leave port4 bits 2,3 open
// - Leave port5 pins open
// - VPP only for write, verify, disable
// - Port1 upper carry A4-A10; bit0 open
`timescale 1ns/1ps
`include "prom_prog_params.svh"
module prom_programmer
	import prom_prog_pkg::*;
(
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic large_variant_i,
	input wire logic req_valid_i,
	input wire req_s req_i,
	output logic req_ready_o,
	output logic done_o,
	output logic range_err_o,
	output logic mismatch_o,
	output logic [`DATA_W-1:0] rd_data_o,
	input wire logic [`DATA_W-1:0] port0_pins_i,
	output logic [`DATA_W-1:0] port0_pins_o,
	output logic port0_pins_oe_o,
	output logic [1:0] port3_low_o,
	output logic port3_bit2_o,
	output logic port3_bit3_o,
	output logic [1:0] port4_low_o,
	output logic vref_o,
	output logic [6:0] port1_upper_pins_o,
	output logic [3:0] port2_low_pins_o,
	output logic reset_n_o
);
	localparam logic [`CNT_W-1:0] SETUP_C = `CNT_W'(`SETUP_CYC);
	localparam logic [`CNT_W-1:0] PULSE_C = `CNT_W'(`PULSE_CYC);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SETUP,
		ST_STROBE,
		ST_HOLD,
		ST_DONE
	} state_e;

	function automatic logic in_area(input logic [`ADDR_W-1:0] a, input logic big);
		logic [`ADDR_W-1:0] lo;
		lo = big ? `LARGE_LO : `SMALL_LO;
		in_area = (a >= lo) && (a <= `AREA_HI);
	endfunction : in_area

	state_e state_reg, state_next;
	pins_s pins_reg, pins_next;
	req_s req_reg, req_next;
	logic [`CNT_W-1:0] cnt_reg, cnt_next;
	logic [`DATA_W-1:0] dout_reg, dout_next;
	logic drive_reg, drive_next;
	logic done_reg, done_next;
	logic err_reg, err_next;
	logic mis_reg, mis_next;
	logic [`DATA_W-1:0] rd_reg, rd_next;

	always_comb begin
		state_next = state_reg;
		pins_next = pins_reg;
		req_next = req_reg;
		cnt_next = cnt_reg;
		dout_next = dout_reg;
		drive_next = drive_reg;
		done_next = 1'b0;
		err_next = err_reg;
		mis_next = mis_reg;
		rd_next = rd_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (req_valid_i) begin
					req_next = req_i;
					err_next = 1'b0;
					mis_next = 1'b0;
					if (req_i.op == OP_WRITE && !in_area(req_i.addr, large_variant_i)) begin
						err_next = 1'b1;
						state_next = ST_DONE;
					end else begin
						pins_next.prom_word_index = req_i.addr;
						pins_next.vpp_on = (req_i.op != OP_READ);
						pins_next.out_en_n = (req_i.op == OP_WRITE);
						pins_next.chip_en_n = 1'b1;
						dout_next = req_i.data;
						drive_next = (req_i.op == OP_WRITE);
						cnt_next = SETUP_C;
						state_next = ST_SETUP;
					end
				end
			end
			ST_SETUP: begin
				cnt_next = cnt_reg - `CNT_W'(1);
				if (cnt_reg <= `CNT_W'(1)) begin
					// CE low; verify keeps CE high
					pins_next.chip_en_n = (req_reg.op == OP_VERIFY);
					if (req_reg.op == OP_VERIFY)
						pins_next.out_en_n = 1'b0;
					if (req_reg.op == OP_READ)
						pins_next.out_en_n = 1'b0;
					cnt_next = PULSE_C;
					state_next = ST_STROBE;
				end
			end
			ST_STROBE: begin
				cnt_next = cnt_reg - `CNT_W'(1);
				if (cnt_reg <= `CNT_W'(1)) begin
					if (req_reg.op != OP_WRITE) begin
						rd_next = port0_pins_i;
						mis_next = (req_reg.op == OP_VERIFY) && (port0_pins_i != req_reg.data);
					end
					pins_next.chip_en_n = 1'b1;
					pins_next.out_en_n = 1'b1;
					cnt_next = SETUP_C;
					state_next = ST_HOLD;
				end
			end
			ST_HOLD: begin
				cnt_next = cnt_reg - `CNT_W'(1);
				if (cnt_reg <= `CNT_W'(1)) begin
					drive_next = 1'b0;
					pins_next.vpp_on = 1'b0;
					state_next = ST_DONE;
				end
			end
			ST_DONE: begin
				done_next = 1'b1;
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_reg <= ST_IDLE;
			pins_reg <= '{reset_n: 1'b0, chip_en_n: 1'b1, out_en_n: 1'b1,
				vpp_on: 1'b0, prom_word_index: '0};
			req_reg <= '0;
			cnt_reg <= '0;
			dout_reg <= '0;
			drive_reg <= 1'b0;
			done_reg <= 1'b0;
			err_reg <= 1'b0;
			mis_reg <= 1'b0;
			rd_reg <= '0;
		end else begin
			state_reg <= state_next;
			pins_reg <= pins_next;
			req_reg <= req_next;
			cnt_reg <= cnt_next;
			dout_reg <= dout_next;
			drive_reg <= drive_next;
			done_reg <= done_next;
			err_reg <= err_next;
			mis_reg <= mis_next;
			rd_reg <= rd_next;
		end
	end

	assign req_ready_o = (state_reg == ST_IDLE);
	assign done_o = done_reg;
	assign range_err_o = err_reg;
	assign mismatch_o = mis_reg;
	assign rd_data_o = rd_reg;
	assign port0_pins_o = dout_reg;
	assign port0_pins_oe_o = drive_reg && pins_reg.out_en_n;

	prom_pin_map u_map (
		.pins_i(pins_reg),
		.port3_low_o(port3_low_o),
		.port3_bit2_o(port3_bit2_o),
		.port3_bit3_o(port3_bit3_o),
		.port4_low_o(port4_low_o),
		.vref_o(vref_o),
		.port1_upper_pins_o(port1_upper_pins_o),
		.port2_low_pins_o(port2_low_pins_o),
		.reset_n_o(reset_n_o)
	);

	// Length of the current chip enable low phase; only the pulse check reads it
	logic [`CNT_W-1:0] ce_low_cnt_reg, ce_low_cnt_next;

	// Saturates so a stuck strobe cannot wrap back to a legal width
	always_comb begin
		ce_low_cnt_next = ce_low_cnt_reg;
		if (pins_reg.chip_en_n)
			ce_low_cnt_next = '0;
		else if (ce_low_cnt_reg != '1)
			ce_low_cnt_next = ce_low_cnt_reg + `CNT_W'(1);
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i)
			ce_low_cnt_reg <= '0;
		else
			ce_low_cnt_reg <= ce_low_cnt_next;
	end

	// Pin sequence checks, all on the controller clock
	no_contention_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		port0_pins_oe_o |-> pins_reg.out_en_n)
		else $error("data driven with output enable low");

	idle_quiet_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		state_reg == ST_IDLE |-> pins_reg.chip_en_n && pins_reg.out_en_n && !port0_pins_oe_o)
		else $error("pins active while idle");

	verify_no_drive_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		state_reg == ST_STROBE && req_reg.op != OP_WRITE |-> !port0_pins_oe_o)
		else $error("data driven while the device answers");

	write_oe_high_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		$fell(pins_reg.chip_en_n) && req_reg.op == OP_WRITE |-> pins_reg.out_en_n && pins_reg.vpp_on)
		else $error("write strobe without oe high and vpp");

	write_data_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		$fell(pins_reg.chip_en_n) && req_reg.op == OP_WRITE |->
		port0_pins_oe_o && port0_pins_o == req_reg.data && $stable(pins_reg.prom_word_index))
		else $error("write data not presented with the address");

	write_strobe_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		state_reg == ST_STROBE && req_reg.op == OP_WRITE |->
		!pins_reg.chip_en_n && pins_reg.out_en_n && pins_reg.vpp_on)
		else $error("write strobe pin levels wrong");

	stable_strobe_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		!pins_reg.chip_en_n && $past(!pins_reg.chip_en_n) |->
		$stable(pins_reg.prom_word_index) && $stable(dout_reg))
		else $error("address or data changed during strobe");

	strobe_count_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		$rose(pins_reg.chip_en_n) |-> ce_low_cnt_reg == PULSE_C)
		else $error("strobe width differs from the pulse count");

	vpp_read_off_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		state_reg != ST_IDLE && req_reg.op == OP_READ |-> !pins_reg.vpp_on)
		else $error("vpp applied during read");

	read_no_vpp_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		!pins_reg.chip_en_n && !pins_reg.out_en_n |-> !pins_reg.vpp_on)
		else $error("vpp applied with both enables low");

	vpp_idle_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		state_reg == ST_IDLE |-> !pins_reg.vpp_on)
		else $error("vpp left on while idle");

	verify_pins_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		state_reg == ST_STROBE && req_reg.op == OP_VERIFY |->
		pins_reg.chip_en_n && !pins_reg.out_en_n && pins_reg.vpp_on)
		else $error("verify pin levels wrong");

	area_check_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		state_reg == ST_STROBE && req_reg.op == OP_WRITE |->
		in_area(pins_reg.prom_word_index, large_variant_i))
		else $error("write outside programmable area");

	range_refused_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		$rose(range_err_o) |-> state_reg == ST_DONE && !pins_reg.vpp_on && !port0_pins_oe_o)
		else $error("refused write touched the pins");

	large_area_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		large_variant_i && state_reg == ST_STROBE && req_reg.op == OP_WRITE |->
		pins_reg.prom_word_index >= `LARGE_LO)
		else $error("write below the large programmable area");

	reset_held_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		!reset_n_o)
		else $error("device reset released");

	strobe_width_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		state_reg == ST_SETUP ##1 state_reg == ST_STROBE |->
		(state_reg == ST_STROBE) [*8])
		else $error("write strobe too short");
endmodule : prom_programmer

// [tb_top.sv]
// Self-checking bench for the PROM programmer with a device model.
// Assumes the package and parameter header are compiled first.
`timescale 1ns/1ps
`include "prom_prog_params.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
	$display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module tb_top;
	import prom_prog_pkg::*;
	typedef struct packed {logic err; logic mis; logic cd; logic [7:0] d;} note_s;
	logic clock_i = 1'b0, rstn_i = 1'b0, large_variant_i = 1'b0, req_valid_i = 1'b0;
	logic corrupt = 1'b0;
	req_s req_i = '0;
	logic req_ready_o, done_o, range_err_o, mismatch_o, port0_pins_oe_o, port3_bit2_o;
	logic port3_bit3_o, vref_o, reset_n_o;
	logic [7:0] rd_data_o, port0_pins_i, port0_pins_o, d;
	logic [1:0] port3_low_o, port4_low_o;
	logic [6:0] port1_upper_pins_o;
	logic [3:0] port2_low_pins_o;
	logic [31:0] rng = 32'h0000a5f3;
	int n_fail = 0, n_tests = 0;
	note_s notes[$];
	note_s nt;
	always #4 clock_i = ~clock_i;
	prom_programmer i_dut (.clock_i(clock_i), .rstn_i(rstn_i), .large_variant_i(large_variant_i),
		.req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o), .done_o(done_o),
		.range_err_o(range_err_o), .mismatch_o(mismatch_o), .rd_data_o(rd_data_o),
		.port0_pins_i(port0_pins_i), .port0_pins_o(port0_pins_o),
		.port0_pins_oe_o(port0_pins_oe_o), .port3_low_o(port3_low_o),
		.port3_bit2_o(port3_bit2_o), .port3_bit3_o(port3_bit3_o), .port4_low_o(port4_low_o),
		.vref_o(vref_o), .port1_upper_pins_o(port1_upper_pins_o),
		.port2_low_pins_o(port2_low_pins_o), .reset_n_o(reset_n_o));
	prom_device_model i_dev (.port3_low_i(port3_low_o), .port3_bit2_i(port3_bit2_o),
		.port3_bit3_i(port3_bit3_o), .port4_low_i(port4_low_o), .vref_i(vref_o),
		.port1_upper_pins_i(port1_upper_pins_o), .port2_low_pins_i(port2_low_pins_o),
		.reset_n_i(reset_n_o), .host_data_i(port0_pins_o), .host_oe_i(port0_pins_oe_o),
		.corrupt_i(corrupt), .bus_o(port0_pins_i));
	function automatic logic [31:0] xs();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction : xs
	task automatic close_out();
		if (n_fail == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : close_out
	task automatic run(input op_e o, input logic [14:0] ad, input logic [7:0] dt,
		input logic err, input logic mis, input logic cd, input logic [7:0] ex);
		int n;
		notes.push_back('{err, mis, cd, ex});
		req_i <= '{o, ad, dt};
		req_valid_i <= 1'b1;
		do @(posedge clock_i); while (req_ready_o !== 1'b1);
		req_valid_i <= 1'b0;
		n = 0;
		while (done_o !== 1'b1 && n < 400) begin
			@(posedge clock_i);
			n++;
		end
		if (n >= 400) n_fail++;
	endtask : run
	// One write, verify and read round trip
	task automatic trip(input logic [14:0] ad);
		d = xs();
		run(OP_WRITE, ad, d, 1'b0, 1'b0, 1'b0, 8'h00);
		`CHK(i_dev.mem[ad], d)
		run(OP_VERIFY, ad, d, 1'b0, 1'b0, 1'b1, d);
		run(OP_READ, ad, 8'h00, 1'b0, 1'b0, 1'b1, d);
	endtask : trip
	always @(posedge clock_i) begin
		if (done_o === 1'b1) begin
			nt = notes.pop_front();
			`CHK(range_err_o, nt.err)
			`CHK(mismatch_o, nt.mis)
			if (nt.cd) `CHK(rd_data_o, nt.d)
		end
	end
	initial begin
		repeat (20000) @(posedge clock_i);
		n_fail++;
		close_out();
	end
	initial begin
		repeat (8) @(posedge clock_i);
		rstn_i <= 1'b1;
		@(posedge clock_i);
		`CHK({reset_n_o, vref_o, port3_bit2_o, port3_bit3_o}, 4'h6)
		for (int i = 0; i < 15; i++) trip(15'h6000 | ((15'h1 << i) & 15'h1fff));
		trip(15'h7fff);
		trip(15'h6000 | xs() & 15'h1fff);
		run(OP_WRITE, 15'h5fff, 8'h00, 1'b1, 1'b0, 1'b0, 8'h00);
		run(OP_READ, 15'h5fff, 8'h00, 1'b0, 1'b0, 1'b1, 8'hff);
		large_variant_i <= 1'b1;
		trip(15'h4000);
		run(OP_WRITE, 15'h3fff, 8'h00, 1'b1, 1'b0, 1'b0, 8'h00);
		corrupt <= 1'b1;
		run(OP_VERIFY, 15'h4000, d, 1'b0, 1'b1, 1'b1, d ^ 8'h01);
		corrupt <= 1'b0;
		repeat (2) @(posedge clock_i);
		close_out();
	end
endmodule : tb_top
